// >>> rtl/pmc_misc_config.sv
// option, setpoint and control logic of the power module, with its link port
`timescale 1ns/10ps
module pmc_misc_config #(
    parameter int SW_HALF = pmc_pkg::SW_HALF_CYC,
    parameter int LOSS    = pmc_pkg::SYNC_LOSS_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_link_clk,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_write,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [15:0] i_cmd_wdata,
    output logic             o_cmd_ready,
    output logic             o_rsp_valid,
    output logic [15:0]      o_rsp_rdata,
    input  wire logic        i_ov_fault,
    input  wire logic        i_fb_below_0v2,
    input  wire logic        i_on_off_control_pin,
    input  wire logic        i_frequency_select_pin,
    input  wire logic        i_frequency_resistor_open,
    input  wire logic [15:0] i_vout_meas,
    input  wire logic        i_sync_in,
    output logic             o_sync_out,
    output logic             o_sync_oe,
    output logic             o_power_good_output,
    output logic             o_power_good_oe,
    output logic             o_low_side_latch,
    output logic [3:0]       o_oc_limit_eighths,
    output logic             o_level_shift_on,
    output logic             o_conv_enable,
    output logic             o_sw_clk,
    output logic             o_freq_default,
    output logic             o_sync_fault
);
    import pmc_pkg::*;

    if (SW_HALF < 2 || SW_HALF > 255 || LOSS < 2 || LOSS > 255) begin : g_bad
        $error("pmc_misc_config: divider or loss count out of range");
    end

    localparam logic [7:0] HALF_M1 = 8'(SW_HALF - 1);
    localparam logic [7:0] LOSS_W  = 8'(LOSS);

    pmc_xfer_if xf ();

    pmc_link_port u_link (
        .i_link_clk  (i_link_clk),
        .i_reset_n   (i_reset_n),
        .i_cmd_valid (i_cmd_valid),
        .i_cmd_write (i_cmd_write),
        .i_cmd_code  (i_cmd_code),
        .i_cmd_wdata (i_cmd_wdata),
        .o_cmd_ready (o_cmd_ready),
        .o_rsp_valid (o_rsp_valid),
        .o_rsp_rdata (o_rsp_rdata),
        .xf          (xf.link)
    );

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [1:0]  ov_s;
        logic [1:0]  fb_s;
        logic [1:0]  on_off_control_pin_s;
        logic [2:0]  syi_s;
        logic [1:0]  fsel_s;
        logic [1:0]  fres_s;
        logic [2:0]  req_s;
        logic        ack;
        logic [15:0] rdata;
        logic [15:0] setpoint;
        logic [15:0] fb_scale;
        logic [15:0] misc;
        logic [7:0]  onoff;
        logic [7:0]  oper;
        logic [7:0]  ov_resp;
        logic [15:0] nv_setpoint;
        logic [15:0] nv_fb_scale;
        logic [15:0] nv_misc;
        logic [7:0]  nv_onoff;
        logic [7:0]  nv_ov_resp;
        logic        boot;
        logic        conv_en;
        logic        ov_latch;
        logic        ls_active;
        logic [7:0]  div_cnt;
        logic        int_clk;
        logic        sw_clk;
        logic [7:0]  loss_cnt;
        logic        sync_lost;
        logic        sync_o;
        logic        sync_oe;
        logic        pg_oe;
        logic [3:0]  oc_x;
        logic        freq_def;
        logic        fault_out;
    } pmc_st_t;

    pmc_st_t st;
    pmc_st_t next_st;

    function automatic logic [3:0] oc_map(input logic [1:0] t);
        case (t)
            2'b01:   oc_map = OC_X_UP;
            2'b10:   oc_map = OC_X_DN25;
            2'b11:   oc_map = OC_X_DN12;
            default: oc_map = OC_X_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // combinational next state

    logic        cmd_new;
    logic        ov_ignore;
    logic        on_off_control_pin_ok;
    logic        want_on;
    logic        clr_cmd;
    logic        in_mode;
    logic        sync_edge;
    logic [22:0] v100;
    logic [22:0] lo_lim;
    logic [22:0] hi_lim;

    always_comb begin
        next_st = st;
        next_st.ov_s   = {st.ov_s[0], i_ov_fault};
        next_st.fb_s   = {st.fb_s[0], i_fb_below_0v2};
        next_st.on_off_control_pin_s = {st.on_off_control_pin_s[0], i_on_off_control_pin};
        next_st.syi_s  = {st.syi_s[1:0], i_sync_in};
        next_st.fsel_s = {st.fsel_s[0], i_frequency_select_pin};
        next_st.fres_s = {st.fres_s[0], i_frequency_resistor_open};
        next_st.req_s  = {st.req_s[1:0], xf.req_tgl};
        next_st.boot   = 1'b0;
        cmd_new = st.req_s[2] != st.req_s[1];
        clr_cmd = cmd_new && xf.wr && xf.code == CMD_CLEAR_FLT;
        // register access; answer toggles one cycle after the command lands
        if (cmd_new) begin
            next_st.ack = ~st.ack;
            if (xf.wr) begin
                case (xf.code)
                    CMD_OPERATION:  next_st.oper = xf.wdata[7:0];
                    CMD_ON_OFF_CFG: next_st.onoff = xf.wdata[7:0];
                    CMD_SETPOINT:   next_st.setpoint = xf.wdata;
                    CMD_FB_SCALE:   next_st.fb_scale = xf.wdata;
                    CMD_OV_RESP:    next_st.ov_resp = xf.wdata[7:0];
                    CMD_MISC_OPT:
                        next_st.misc = xf.wdata & MISC_WR_MASK;
                    CMD_STORE_ALL: begin
                        next_st.nv_setpoint = st.setpoint;
                        next_st.nv_fb_scale = st.fb_scale;
                        next_st.nv_misc     = st.misc;
                        next_st.nv_onoff    = st.onoff;
                        next_st.nv_ov_resp  = st.ov_resp;
                    end
                    CMD_RESTORE_ALL: next_st.boot = 1'b1;
                    default: ;
                endcase
            end else begin
                case (xf.code)
                    CMD_OPERATION:  next_st.rdata = {8'h00, st.oper};
                    CMD_ON_OFF_CFG: next_st.rdata = {8'h00, st.onoff};
                    CMD_SETPOINT:   next_st.rdata = st.setpoint;
                    CMD_FB_SCALE:   next_st.rdata = st.fb_scale;
                    CMD_OV_RESP:    next_st.rdata = {8'h00, st.ov_resp};
                    CMD_MISC_OPT:   next_st.rdata = st.misc;
                    CMD_STATUS_OWN: next_st.rdata = {11'h000, st.fault_out,
                        st.pg_oe, st.ls_active, st.ov_latch, st.conv_en};
                    default:        next_st.rdata = 16'h0000;
                endcase
            end
        end

        // nvm contents become the working values after a power-up load
        if (st.boot) begin
            next_st.setpoint = st.nv_setpoint;
            next_st.fb_scale = st.nv_fb_scale;
            next_st.misc     = st.nv_misc;
            next_st.onoff    = st.nv_onoff;
            next_st.ov_resp  = st.nv_ov_resp;
        end

        // conversion gate from pin and bus
        on_off_control_pin_ok = (st.on_off_control_pin_s[1] == st.onoff[ONOFF_POL_BIT])
                  || !st.onoff[ONOFF_PIN_BIT];
        want_on = on_off_control_pin_ok && (st.oper[OPER_ON_BIT]
                  || !st.onoff[ONOFF_BUS_BIT]);
        next_st.conv_en = want_on;
        // level shifter state frozen while switching
        if (want_on && !st.conv_en) begin
            next_st.ls_active = st.misc[MISC_LS_EN];
        end else if (!want_on) begin
            next_st.ls_active = 1'b0;
        end

        // low-side latch; a fresh fault beats any release in the same cycle
        ov_ignore = st.ov_resp[7:6] == 2'b00;
        if (st.ov_s[1] && !ov_ignore) begin
            next_st.ov_latch = 1'b1;
        end else if (!st.misc[MISC_OV_POLICY]) begin
            if ((want_on && !st.conv_en) || (clr_cmd && !st.conv_en)) begin
                next_st.ov_latch = 1'b0;
            end
        end else if (st.fb_s[1]) begin
            next_st.ov_latch = 1'b0;
        end

        next_st.oc_x = oc_map(st.misc[MISC_TRIM_LO +: 2]);
        next_st.freq_def = !st.fsel_s[1] && st.fres_s[1];
        // internal free-running switching clock
        if (st.div_cnt == HALF_M1) begin
            next_st.div_cnt = 8'h00;
            next_st.int_clk = ~st.int_clk;
        end else begin
            next_st.div_cnt = st.div_cnt + 8'h01;
        end
        // loss detector on the external clock; input mode wins over output
        in_mode   = st.misc[MISC_SYNC_IN];
        sync_edge = st.syi_s[2] != st.syi_s[1];
        if (!in_mode || sync_edge) begin
            next_st.loss_cnt  = 8'h00;
            next_st.sync_lost = 1'b0;
        end else if (st.loss_cnt == LOSS_W) begin
            next_st.sync_lost = 1'b1;
        end else begin
            next_st.loss_cnt = st.loss_cnt + 8'h01;
        end
        // masked fault: neither reported nor acted on
        next_st.fault_out = st.sync_lost
                            && !st.misc[MISC_SYNC_MASK];
        if (in_mode && (!st.sync_lost || st.misc[MISC_SYNC_MASK])) begin
            next_st.sw_clk = st.syi_s[1];
        end else begin
            next_st.sw_clk = st.int_clk;
        end
        next_st.sync_oe = st.misc[MISC_SYNC_OUT] && !in_mode;
        next_st.sync_o  = st.int_clk;

        // window check in percent, widened to avoid overflow
        lo_lim = 23'(st.setpoint) * 23'(PG_LO_PCT);
        hi_lim = 23'(st.setpoint) * 23'(PG_HI_PCT);
        v100   = 23'(i_vout_meas) * 23'(PG_FULL);
        next_st.pg_oe = !(st.conv_en && v100 >= lo_lim
                          && v100 <= hi_lim);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
            st.setpoint    <= SETPOINT_RESET;
            st.fb_scale    <= FB_SCALE_RESET;
            st.misc        <= MISC_RESET;
            st.onoff       <= ONOFF_RESET;
            st.oper        <= OPER_RESET;
            st.ov_resp     <= OV_RESP_RESET;
            st.nv_setpoint <= SETPOINT_RESET;
            st.nv_fb_scale <= FB_SCALE_RESET;
            st.nv_misc     <= MISC_RESET;
            st.nv_onoff    <= ONOFF_RESET;
            st.nv_ov_resp  <= OV_RESP_RESET;
            st.boot        <= 1'b1;
            st.oc_x        <= OC_X_NONE;
            st.pg_oe       <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign xf.ack_tgl           = st.ack;
    assign xf.rdata             = st.rdata;
    assign o_sync_out           = st.sync_o;
    assign o_sync_oe            = st.sync_oe;
    assign o_power_good_output  = 1'b0;
    assign o_power_good_oe      = st.pg_oe;
    assign o_low_side_latch     = st.ov_latch;
    assign o_oc_limit_eighths   = st.oc_x;
    assign o_level_shift_on     = st.ls_active;
    assign o_conv_enable        = st.conv_en;
    assign o_sw_clk             = st.sw_clk;
    assign o_freq_default       = st.freq_def;
    assign o_sync_fault         = st.fault_out;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    sequence s_cmd_lands;
        st.req_s[2] != st.req_s[1];
    endsequence
    sequence s_answer;
        ##1 (st.ack != $past(st.ack));
    endsequence

    a_cmd_answer: assert property (s_cmd_lands |-> s_answer)
        else $error("command not answered next cycle");
    a_misc_readback: assert property (s_cmd_lands and
        (!xf.wr && xf.code == CMD_MISC_OPT) |=> st.rdata == (st.misc
        & MISC_WR_MASK))
        else $error("option read not masked last value");
    a_ov_latch_set: assert property (st.ov_s[1] && st.ov_resp[7:6] != 2'b00
        |=> o_low_side_latch)
        else $error("ov fault did not latch low side");
    a_ov_hold_zero: assert property (st.ov_latch && !st.misc[0]
        && st.conv_en && !$rose(st.conv_en) |=> st.ov_latch)
        else $error("latch released while running");
    a_ov_release_one: assert property (st.misc[0] && st.fb_s[1]
        && !st.ov_s[1] |=> !st.ov_latch)
        else $error("latch not released below 0.2 v");
    a_oc_trim_map: assert property (st.misc[2:1] == 2'b10
        |-> ##1 o_oc_limit_eighths == OC_X_DN25)
        else $error("trim -25 percent wrong");
    a_ls_frozen: assert property (st.conv_en && $past(st.conv_en)
        && next_st.conv_en |=> $stable(o_level_shift_on))
        else $error("level shift changed while switching");
    a_ls_needs_en: assert property ($rose(o_level_shift_on)
        |-> $past(st.misc[MISC_LS_EN]))
        else $error("level shift on without enable");
    a_sync_masked: assert property (st.misc[MISC_SYNC_MASK]
        |=> !o_sync_fault)
        else $error("masked sync fault reported");
    a_sync_drive: assert property (o_sync_oe
        |-> $past(st.misc[MISC_SYNC_OUT]))
        else $error("sync pin driven without force out");
    a_on_off_control_pin_gate: assert property (st.onoff == ONOFF_RESET && !st.on_off_control_pin_s[1]
        |=> !o_conv_enable)
        else $error("conversion with pin low");
    a_pg_off: assert property (!st.conv_en |=> o_power_good_oe)
        else $error("power good released while off");
endmodule

// >>> rtl/pmc_pkg.sv
// shared constants of the power-module option and control block
package pmc_pkg;

    // command codes
    localparam logic [7:0] CMD_OPERATION   = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FLT   = 8'h03;
    localparam logic [7:0] CMD_STORE_ALL   = 8'h11;
    localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
    localparam logic [7:0] CMD_SETPOINT    = 8'h21;
    localparam logic [7:0] CMD_FB_SCALE    = 8'h29;
    localparam logic [7:0] CMD_OV_RESP     = 8'h41;
    localparam logic [7:0] CMD_STATUS_OWN  = 8'h80;
    localparam logic [7:0] CMD_MISC_OPT    = 8'hf0;

    // option register fields
    localparam int MISC_OV_POLICY = 0;
    localparam int MISC_TRIM_LO   = 1;
    localparam int MISC_LS_EN     = 4;
    localparam int MISC_SYNC_OUT  = 6;
    localparam int MISC_SYNC_IN   = 7;
    localparam int MISC_SYNC_MASK = 8;
    localparam logic [15:0] MISC_WR_MASK = 16'h01d7;
    localparam logic [15:0] MISC_RESET   = 16'h0193;

    // other fields and factory values
    localparam int OPER_ON_BIT   = 7;
    localparam int ONOFF_POL_BIT = 1;
    localparam int ONOFF_PIN_BIT = 2;
    localparam int ONOFF_BUS_BIT = 3;
    localparam logic [7:0]  ONOFF_RESET    = 8'h16;
    localparam logic [7:0]  OPER_RESET     = 8'h00;
    localparam logic [7:0]  OV_RESP_RESET  = 8'hb8;
    localparam logic [15:0] SETPOINT_RESET = 16'h0266;
    localparam logic [15:0] FB_SCALE_RESET = 16'h0001;

    // power-good window in percent
    localparam logic [6:0] PG_LO_PCT = 7'h5f;
    localparam logic [6:0] PG_HI_PCT = 7'h69;
    localparam logic [6:0] PG_FULL   = 7'h64;

    // trim in eighths of the default limit
    localparam logic [3:0] OC_X_NONE = 4'h8;
    localparam logic [3:0] OC_X_UP   = 4'h9;
    localparam logic [3:0] OC_X_DN25 = 4'h6;
    localparam logic [3:0] OC_X_DN12 = 4'h7;

    // timing
    localparam int CLK_HZ       = 25000000;
    localparam int FSW_HZ       = 500000;
    localparam int SW_HALF_CYC  = CLK_HZ / (2 * FSW_HZ);
    localparam int SYNC_LOSS_NS = 4000;
    localparam int CLK_NS       = 40;
    localparam int SYNC_LOSS_CYC = SYNC_LOSS_NS / CLK_NS;

endpackage

// >>> rtl/pmc_xfer_if.sv
// command crossing between the link clock domain and the main clock domain
`timescale 1ns/10ps
interface pmc_xfer_if;
    logic        req_tgl;
    logic        wr;
    logic [7:0]  code;
    logic [15:0] wdata;
    logic        ack_tgl;
    logic [15:0] rdata;

    modport link (output req_tgl, output wr, output code, output wdata,
                  input ack_tgl, input rdata);
    modport core (input req_tgl, input wr, input code, input wdata,
                  output ack_tgl, output rdata);
endinterface

// >>> rtl/pmc_link_port.sv
// link-clock side of the command port: takes one command, waits for the answer
`timescale 1ns/10ps
module pmc_link_port (
    input  wire logic        i_link_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_write,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [15:0] i_cmd_wdata,
    output logic             o_cmd_ready,
    output logic             o_rsp_valid,
    output logic [15:0]      o_rsp_rdata,
    pmc_xfer_if.link         xf
);
    import pmc_pkg::*;

    typedef struct packed {
        logic        busy;
        logic        req;
        logic        wr;
        logic [7:0]  code;
        logic [15:0] wdata;
        logic        ack_s1;
        logic        ack_s2;
        logic        rsp_v;
        logic [15:0] rsp_d;
        logic        idle;
    } pmc_lp_t;

    pmc_lp_t st;
    pmc_lp_t next_st;

    always_comb begin
        next_st = st;
        next_st.rsp_v = 1'b0;
        next_st.ack_s1 = xf.ack_tgl;
        next_st.ack_s2 = st.ack_s1;
        if (!st.busy && i_cmd_valid) begin
            // fields held stable until the answer returns
            next_st.busy  = 1'b1;
            next_st.wr    = i_cmd_write;
            next_st.code  = i_cmd_code;
            next_st.wdata = i_cmd_wdata;
            next_st.req   = ~st.req;
        end else if (st.busy && st.ack_s2 == st.req) begin
            next_st.busy  = 1'b0;
            next_st.rsp_v = 1'b1;
            next_st.rsp_d = xf.rdata;
        end
        // ready is its own flop so the pin has no gate after the register
        next_st.idle = !next_st.busy;
    end

    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
            st.idle <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign xf.req_tgl  = st.req;
    assign xf.wr       = st.wr;
    assign xf.code     = st.code;
    assign xf.wdata    = st.wdata;
    assign o_cmd_ready = st.idle;
    assign o_rsp_valid = st.rsp_v;
    assign o_rsp_rdata = st.rsp_d;
endmodule

// >>> verif/pmc_host_model.sv
// host model: issues one command at a time on the link clock
`timescale 1ns/10ps
module pmc_host_model (
    input  wire logic        i_link_clk,
    input  wire logic        i_cmd_ready,
    input  wire logic        i_rsp_valid,
    input  wire logic [15:0] i_rsp_rdata,
    output logic             o_cmd_valid,
    output logic             o_cmd_write,
    output logic [7:0]       o_cmd_code,
    output logic [15:0]      o_cmd_wdata
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_write = 1'b0;
        o_cmd_code  = 8'h00;
        o_cmd_wdata = 16'h0000;
    end
    // setpoint goes to 21h as volts times 512; the scale at 29h is never
    // rewritten, so it stays at 1
    // a store at 11h is the only way a value becomes the default
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] d, output logic [15:0] r,
                        output bit ok);
        int n;
        ok = 1'b0;
        r = 16'h0000;
        @(negedge i_link_clk);
        for (n = 0; n < 20 && i_cmd_ready !== 1'b1; n++) begin
            @(negedge i_link_clk);
        end
        o_cmd_valid = 1'b1;
        o_cmd_write = w;
        o_cmd_code  = c;
        o_cmd_wdata = d;
        @(negedge i_link_clk);
        // released fields show junk so a stale value cannot pass
        o_cmd_valid = 1'b0;
        o_cmd_write = ~w;
        o_cmd_code  = ~c;
        o_cmd_wdata = ~d;
        for (n = 0; n < 20 && !ok; n++) begin
            if (i_rsp_valid === 1'b1) begin
                r = i_rsp_rdata;
                ok = 1'b1;
            end else begin
                @(negedge i_link_clk);
            end
        end
    endtask
endmodule

// >>> verif/pmbus_misc_config_control_tb_top.sv
// testbench top: commands, pins and checks for the option block
`timescale 1ns/10ps
module pmbus_misc_config_control_tb_top;
    import pmc_pkg::*;
    logic        i_mclk = 0, i_link_clk = 0, i_reset_n = 0;
    logic        ov = 0, fbl = 0, pin = 0, fsel = 0, fopen = 1, syn = 0;
    logic [15:0] vout = 16'h0266;
    logic        cv, cw, rdy, rv, so, soe, pg, pgoe, lsl, lson, conv;
    logic        swc, fdef, sflt, s0;
    logic [7:0]  cc;
    logic [15:0] cd, rr;
    logic [3:0]  oc;
    logic [3:0]  oc_exp [4] = '{4'h8, 4'h9, 4'h6, 4'h7};
    logic [15:0] pg_v [4] = '{16'd583, 16'd584, 16'd644, 16'd645};
    logic        pg_e [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int          mismatches = 0;
    int          n_tests = 0;
    initial forever #20 i_mclk = ~i_mclk;
    initial begin
        #7;
        forever #32 i_link_clk = ~i_link_clk;
    end
    pmc_misc_config #(.SW_HALF(4), .LOSS(4)) i_pmc_misc_config (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_link_clk(i_link_clk),
        .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_code(cc),
        .i_cmd_wdata(cd), .o_cmd_ready(rdy), .o_rsp_valid(rv),
        .o_rsp_rdata(rr), .i_ov_fault(ov), .i_fb_below_0v2(fbl),
        .i_on_off_control_pin(pin), .i_frequency_select_pin(fsel),
        .i_frequency_resistor_open(fopen), .i_vout_meas(vout),
        .i_sync_in(syn), .o_sync_out(so), .o_sync_oe(soe),
        .o_power_good_output(pg), .o_power_good_oe(pgoe),
        .o_low_side_latch(lsl), .o_oc_limit_eighths(oc),
        .o_level_shift_on(lson), .o_conv_enable(conv), .o_sw_clk(swc),
        .o_freq_default(fdef), .o_sync_fault(sflt));
    pmc_host_model i_pmc_host_model (
        .i_link_clk(i_link_clk), .i_cmd_ready(rdy), .i_rsp_valid(rv),
        .i_rsp_rdata(rr), .o_cmd_valid(cv), .o_cmd_write(cw),
        .o_cmd_code(cc), .o_cmd_wdata(cd));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xf(input logic w, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] r);
        bit ok;
        i_pmc_host_model.xfer(w, c, d, r, ok);
        @(negedge i_mclk);
        if (!ok) begin
            mismatches++;
            $display("MISMATCH answer to %h expected 1 seen 0", c);
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] r;
        xf(1'b0, c, 16'h0000, r);
        chk($sformatf("register %h", c), e, r);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] r;
        xf(1'b1, c, d, r);
    endtask
    // pins pass two sync flops and an output register
    task automatic settle;
        repeat (6) @(negedge i_mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge i_mclk);
        i_reset_n = 1'b1;
        rd(CMD_MISC_OPT, 16'h0193);
        rd(CMD_SETPOINT, 16'h0266);
        rd(8'h55, 16'h0000);
        chk("freq default", 16'h0001, {15'h0, fdef});
        fsel = 1'b1;
        settle();
        chk("freq default", 16'h0000, {15'h0, fdef});
        fsel = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(CMD_MISC_OPT, 16'h0191 | 16'(i << 1));
            settle();
            chk("oc limit", {12'h0, oc_exp[i]}, {12'h0, oc});
        end
        wr(CMD_MISC_OPT, 16'hffff);
        rd(CMD_MISC_OPT, 16'h01d7);
        wr(CMD_MISC_OPT, 16'h0193);
        $display("test registers done");
        chk("conv off", 16'h0000, {15'h0, conv});
        pin = 1'b1;
        settle();
        chk("conv on", 16'h0001, {15'h0, conv});
        chk("shift on", 16'h0001, {15'h0, lson});
        wr(CMD_MISC_OPT, 16'h0183);
        settle();
        chk("shift held", 16'h0001, {15'h0, lson});
        for (int i = 0; i < 4; i++) begin
            vout = pg_v[i];
            settle();
            chk("pg pull", {15'h0, pg_e[i]}, {15'h0, pgoe});
        end
        pin = 1'b0;
        settle();
        chk("pg off", 16'h0001, {15'h0, pgoe});
        chk("pg level", 16'h0000, {15'h0, pg});
        pin = 1'b1;
        settle();
        chk("shift off", 16'h0000, {15'h0, lson});
        wr(CMD_ON_OFF_CFG, 16'h0014);
        pin = 1'b0;
        settle();
        chk("low active", 16'h0001, {15'h0, conv});
        wr(CMD_ON_OFF_CFG, 16'h0016);
        pin = 1'b1;
        $display("test conversion done");
        ov = 1'b1;
        settle();
        chk("ov latch", 16'h0001, {15'h0, lsl});
        ov = 1'b0;
        settle();
        chk("ov held", 16'h0001, {15'h0, lsl});
        fbl = 1'b1;
        settle();
        chk("ov release", 16'h0000, {15'h0, lsl});
        wr(CMD_MISC_OPT, 16'h0182);
        ov = 1'b1;
        settle();
        ov = 1'b0;
        wr(CMD_CLEAR_FLT, 16'h0000);
        settle();
        chk("ov kept", 16'h0001, {15'h0, lsl});
        pin = 1'b0;
        settle();
        wr(CMD_CLEAR_FLT, 16'h0000);
        settle();
        chk("ov cleared", 16'h0000, {15'h0, lsl});
        fbl = 1'b0;
        wr(CMD_OV_RESP, 16'h0038);
        ov = 1'b1;
        settle();
        chk("ov ignored", 16'h0000, {15'h0, lsl});
        ov = 1'b0;
        $display("test overvoltage done");
        wr(CMD_MISC_OPT, 16'h0040);
        settle();
        chk("sync drive", 16'h0001, {15'h0, soe});
        s0 = so;
        repeat (4) @(negedge i_mclk);
        chk("sync out", {15'h0, ~s0}, {15'h0, so});
        wr(CMD_MISC_OPT, 16'h0180);
        for (int i = 0; i < 6; i++) begin
            syn = ~syn;
            settle();
            chk("sync follow", {15'h0, syn}, {15'h0, swc});
        end
        chk("sync input", 16'h0000, {15'h0, soe});
        repeat (20) @(negedge i_mclk);
        chk("sync masked", 16'h0000, {15'h0, sflt});
        wr(CMD_MISC_OPT, 16'h0080);
        repeat (20) @(negedge i_mclk);
        chk("sync fault", 16'h0001, {15'h0, sflt});
        rd(CMD_STATUS_OWN, 16'h0018);
        $display("test sync done");
        wr(CMD_ON_OFF_CFG, 16'h001a);
        settle();
        chk("bus off", 16'h0000, {15'h0, conv});
        wr(CMD_OPERATION, 16'h0080);
        settle();
        chk("bus on", 16'h0001, {15'h0, conv});
        rd(CMD_OPERATION, 16'h0080);
        rd(CMD_FB_SCALE, 16'h0001);
        wr(CMD_SETPOINT, 16'h0300);
        wr(CMD_STORE_ALL, 16'h0000);
        wr(CMD_SETPOINT, 16'h0100);
        rd(CMD_SETPOINT, 16'h0100);
        wr(CMD_RESTORE_ALL, 16'h0000);
        rd(CMD_SETPOINT, 16'h0300);
        $display("test store done");
        tally_and_finish();
    end
endmodule
